// ### bench/test_mul_div_compare_unit.sv
`timescale 1ns/10ps
module test_mul_div_compare_unit;
  logic clk_sys_i, reset_n_i, start_i, hold;
  mdc_pkg::mdc_op_e op_i;
  mdc_pkg::mdc_src_e src_i;
  logic [31:0] acc_i, operand_i, acc_o;
  logic [3:0] addr_corr_i, flags_o, flag_we_o, fwe;
  logic busy_o, done_o, acc_we_o, operand_we_o, mem_rd_o, mem_wr_o, awe, owe;
  logic [15:0] operand_o;
  int fail_count, checks, n, rdc, wrc;

  mdc_unit dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .start_i(start_i), .op_i(op_i), .src_i(src_i),
    .acc_i(acc_i), .operand_i(operand_i), .addr_corr_i(addr_corr_i), .busy_o(busy_o), .done_o(done_o),
    .acc_o(acc_o), .acc_we_o(acc_we_o), .operand_o(operand_o), .operand_we_o(operand_we_o),
    .flags_o(flags_o), .flag_we_o(flag_we_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o)
  );

  initial begin
    clk_sys_i = 0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Counts cycles from the take edge to done; with hold set, start stays up to prove it is ignored
  task run(input logic [31:0] a, input logic [31:0] b, input logic [3:0] c, input int e);
    acc_i = a;
    operand_i = b;
    addr_corr_i = c;
    start_i = 1;
    rdc = 0;
    @(posedge clk_sys_i);
    #1;
    start_i = hold;
    n = 1;
    while (done_o !== 1'b1 && n < 60) begin
      rdc += mem_rd_o;
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    rdc += mem_rd_o;
    wrc = mem_wr_o;
    awe = acc_we_o;
    owe = operand_we_o;
    fwe = flag_we_o;
    start_i = 0;
    chk(n, e);
    @(posedge clk_sys_i);
    #1;
    chk(busy_o, 0);
  endtask

  task sc_reset;
    op_i = mdc_pkg::op_signed_quotient_word;
    src_i = mdc_pkg::src_reg;
    acc_i = 32'h0001_0000;
    operand_i = 32'h3;
    start_i = 1;
    @(posedge clk_sys_i);
    #1;
    start_i = 0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    reset_n_i = 0;
    #1;
    chk({busy_o, done_o, acc_we_o}, 0);
    @(posedge clk_sys_i);
    #1;
    reset_n_i = 1;
  endtask

  task sc_compare;
    op_i = mdc_pkg::op_compare_byte;
    src_i = mdc_pkg::src_acc;
    run(32'h0012_0034, 32'h0, 4'h0, 1);
    chk({awe, owe, fwe, flags_o}, 10'h0f9);
    op_i = mdc_pkg::op_compare_word;
    src_i = mdc_pkg::src_imm;
    run(32'h0000_8000, 32'h1, 4'h0, 2);
    chk(flags_o, 4'h2);
    op_i = mdc_pkg::op_compare_long;
    src_i = mdc_pkg::src_mem;
    run(32'h1234_5678, 32'h1234_5678, 4'h2, 9);
    chk({awe, flags_o}, 5'h04);
    src_i = mdc_pkg::src_reg;
    run(32'h0000_0001, 32'h2, 4'h0, 6);
    chk(flags_o, 4'h9);
  endtask

  task sc_uq_byte;
    op_i = mdc_pkg::op_unsigned_quotient_byte;
    src_i = mdc_pkg::src_acc;
    run(32'h0064_0007, 32'h0, 4'h0, 15);
    chk({awe, fwe, flags_o[1:0]}, 7'h4c);
    chk(acc_o, 32'h0002_000e);
    run(32'h0064_0000, 32'h0, 4'h0, 3);
    chk({awe, flags_o[1:0]}, 3'h3);
    run(32'h1000_0002, 32'h0, 4'h0, 7);
    chk({awe, flags_o[1:0]}, 3'h2);
    src_i = mdc_pkg::src_mem;
    run(32'h0000_0064, 32'h7, 4'h3, 22);
    chk(rdc + wrc, 2);
    chk({acc_o[15:0], operand_o}, 32'h000e_0002);
    run(32'h0000_0064, 32'h0, 4'h3, 9);
    chk(rdc + wrc, 1);
    run(32'h0000_1000, 32'h2, 4'h3, 12);
    chk({owe, rdc[1:0] + wrc[1:0]}, 3'h1);
    src_i = mdc_pkg::src_reg;
    run(32'h0000_0064, 32'h7, 4'h0, 16);
    chk({owe, awe, fwe}, 6'h33);
    chk({acc_o[15:0], operand_o}, 32'h000e_0002);
  endtask

  task sc_uq_word;
    op_i = mdc_pkg::op_unsigned_quotient_word;
    src_i = mdc_pkg::src_reg;
    run(32'h0001_0000, 32'h3, 4'h0, 22);
    chk(owe, 1);
    chk({acc_o[15:0], operand_o}, 32'h5555_0001);
    run(32'h0001_0000, 32'h0, 4'h0, 4);
    run(32'h0003_0000, 32'h2, 4'h0, 7);
    chk({awe, owe, flags_o[1:0]}, 4'h2);
  endtask

  task sc_sq;
    op_i = mdc_pkg::op_signed_quotient_byte;
    src_i = mdc_pkg::src_acc;
    run(32'h0064_00f9, 32'h0, 4'h0, 18);
    chk(acc_o, 32'h0002_00f2);
    run(32'h0064_0000, 32'h0, 4'h0, 3);
    run(32'h7f00_0001, 32'h0, 4'h0, 8);
    chk(flags_o[1], 1);
    // Upper byte below the divisor: overflow found late
    run(32'h0080_0001, 32'h0, 4'h0, 18);
    chk({awe, flags_o[1:0]}, 3'h6);
    src_i = mdc_pkg::src_reg;
    run(32'h0000_0064, 32'hf9, 4'h0, 23);
    chk({acc_o[15:0], operand_o}, 32'h00f2_0002);
    op_i = mdc_pkg::op_signed_quotient_word;
    src_i = mdc_pkg::src_reg;
    run(32'h0001_0000, 32'h3, 4'h0, 31);
    chk({acc_o[15:0], operand_o}, 32'h5555_0001);
    run(32'hffff_0000, 32'h3, 4'h0, 32);
    chk({acc_o[15:0], operand_o}, 32'haaab_ffff);
    run(32'h0001_0000, 32'h0, 4'h0, 4);
    run(32'h0010_0000, 32'h2, 4'h0, 12);
    chk({owe, flags_o[1:0]}, 3'h2);
    run(32'h0001_0000, 32'h2, 4'h0, 30);
    chk(flags_o[1], 1);
  endtask

  task sc_products;
    op_i = mdc_pkg::op_unsigned_product_byte;
    src_i = mdc_pkg::src_acc;
    hold = 1;
    run(32'h0012_0034, 32'h0, 4'h0, 7);
    hold = 0;
    chk({awe, fwe, acc_o[15:0]}, 21'h10_03a8);
    run(32'h0000_0034, 32'h0, 4'h0, 3);
    op_i = mdc_pkg::op_unsigned_product_word;
    run(32'h1234_0002, 32'h0, 4'h0, 11);
    chk(acc_o, 32'h0000_2468);
    run(32'h0000_0002, 32'h0, 4'h0, 3);
    op_i = mdc_pkg::op_signed_product_byte;
    run(32'h00fe_0003, 32'h0, 4'h0, 13);
    chk({fwe, acc_o[15:0]}, 20'h0_fffa);
    run(32'h0002_0003, 32'h0, 4'h0, 12);
    run(32'h0000_0003, 32'h0, 4'h0, 3);
    op_i = mdc_pkg::op_signed_product_word;
    run(32'hffff_0002, 32'h0, 4'h0, 19);
    chk(acc_o, 32'hffff_fffe);
    chk(fwe, 4'h0);
    run(32'h0002_0003, 32'h0, 4'h0, 16);
    run(32'h0000_0003, 32'h0, 4'h0, 3);
    src_i = mdc_pkg::src_reg;
    run(32'h0000_0002, 32'hffff, 4'h0, 20);
    chk(acc_o, 32'hffff_fffe);
    op_i = mdc_pkg::op_unsigned_product_byte;
    src_i = mdc_pkg::src_mem;
    run(32'h0000_0012, 32'h34, 4'h2, 11);
    chk({rdc[1:0], acc_o[15:0]}, 18'h1_03a8);
  endtask

  // Last-resort stop, as each run already gives up at 60 cycles; a few hundred cycles are expected in all
  initial begin
    #300_000;
    fail_count++;
    give_verdict;
  end

  initial begin
    reset_n_i = 0;
    start_i = 0;
    hold = 0;
    op_i = mdc_pkg::op_compare_byte;
    src_i = mdc_pkg::src_acc;
    acc_i = 0;
    operand_i = 0;
    addr_corr_i = 0;
    fail_count = 0;
    checks = 0;
    repeat (10) @(posedge clk_sys_i);
    #1;
    reset_n_i = 1;
    sc_reset;
    sc_compare;
    sc_uq_byte;
    sc_uq_word;
    sc_sq;
    sc_products;
    give_verdict;
  end
endmodule

// ### core/mdc_pkg.sv
package mdc_pkg;

  typedef enum logic [3:0] {
    op_compare_byte,
    op_compare_word,
    op_compare_long,
    op_unsigned_quotient_byte,
    op_unsigned_quotient_word,
    op_signed_quotient_byte,
    op_signed_quotient_word,
    op_unsigned_product_byte,
    op_unsigned_product_word,
    op_signed_product_byte,
    op_signed_product_word
  } mdc_op_e;

  typedef enum logic [1:0] {src_acc, src_reg, src_mem, src_imm} mdc_src_e;

  typedef logic [5:0] mdc_cyc_t;

  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [3:0] FLAGS_ALL = 4'hf;
  localparam logic [3:0] FLAGS_VC = 4'h3;
  localparam logic [3:0] FLAGS_NONE = 4'h0;

  localparam logic [1:0] ROW_ACC = 2'h0;
  localparam logic [1:0] ROW_REG = 2'h1;
  localparam logic [1:0] ROW_MEM = 2'h2;

  localparam logic [31:0] QLIM_UB = 32'h0000_00ff;
  localparam logic [31:0] QLIM_SB_POS = 32'h0000_007f;
  localparam logic [31:0] QLIM_SB_NEG = 32'h0000_0080;
  localparam logic [31:0] QLIM_UW = 32'h0000_ffff;
  localparam logic [31:0] QLIM_SW_POS = 32'h0000_7fff;
  localparam logic [31:0] QLIM_SW_NEG = 32'h0000_8000;

  // Compare: [byte/word/long][source]
  localparam mdc_cyc_t CYC_CMP [3][4] = '{'{6'h01, 6'h02, 6'h03, 6'h02},
                                          '{6'h01, 6'h02, 6'h03, 6'h02},
                                          '{6'h06, 6'h06, 6'h07, 6'h03}};
  // Quotients: [row][zero divisor, overflow, normal]
  localparam mdc_cyc_t CYC_UQB [3][3] = '{'{6'h03, 6'h07, 6'h0f}, '{6'h04, 6'h08, 6'h10}, '{6'h06, 6'h09, 6'h13}};
  localparam mdc_cyc_t CYC_UQW [3][3] = '{'{6'h04, 6'h07, 6'h16}, '{6'h04, 6'h07, 6'h16}, '{6'h06, 6'h08, 6'h1a}};
  // Signed quotients: [row][zero divisor, early overflow, late overflow, normal]
  localparam mdc_cyc_t CYC_SQB [3][4] = '{'{6'h03, 6'h08, 6'h12, 6'h12},
                                          '{6'h04, 6'h0b, 6'h16, 6'h17},
                                          '{6'h05, 6'h0c, 6'h17, 6'h18}};
  // Signed word quotient: [positive/negative dividend][row][outcome]
  localparam mdc_cyc_t CYC_SQW [2][3][4] = '{
    '{'{6'h04, 6'h0c, 6'h1e, 6'h1f}, '{6'h04, 6'h0c, 6'h1e, 6'h1f}, '{6'h05, 6'h0c, 6'h1f, 6'h20}},
    '{'{6'h04, 6'h0c, 6'h1f, 6'h20}, '{6'h04, 6'h0c, 6'h1f, 6'h20}, '{6'h05, 6'h0c, 6'h20, 6'h21}}};
  // Products: [row][zero factor, nonzero] or [row][zero, positive, negative]
  localparam mdc_cyc_t CYC_UPB [3][2] = '{'{6'h03, 6'h07}, '{6'h04, 6'h08}, '{6'h05, 6'h09}};
  localparam mdc_cyc_t CYC_UPW [3][2] = '{'{6'h03, 6'h0b}, '{6'h04, 6'h0c}, '{6'h05, 6'h0d}};
  localparam mdc_cyc_t CYC_SPB [3][3] = '{'{6'h03, 6'h0c, 6'h0d}, '{6'h04, 6'h0d, 6'h0e}, '{6'h05, 6'h0e, 6'h0f}};
  localparam mdc_cyc_t CYC_SPW [3][3] = '{'{6'h03, 6'h10, 6'h13}, '{6'h04, 6'h11, 6'h14}, '{6'h05, 6'h12, 6'h15}};

  typedef struct packed {
    mdc_op_e op;
    mdc_src_e src;
    logic [31:0] acc_res;
    logic [15:0] opnd_res;
    logic [3:0] flags;
    logic [3:0] flag_we;
    logic acc_we;
    logic opnd_we;
    logic mem_rd;
    logic mem_wr;
    logic abort;
    logic sovf;
  } mdc_state_s;

  localparam mdc_state_s STATE_RESET = '0;

  typedef struct packed {
    mdc_cyc_t cnt;
  } mdc_tmr_s;

  localparam mdc_tmr_s TMR_RESET = '0;

endpackage

// ### core/mdc_timer.sv
`timescale 1ns/10ps
module mdc_timer (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Load
  input wire logic load_i,
  input wire mdc_pkg::mdc_cyc_t count_i,
  // Status
  output logic busy_o,
  output logic last_o
);

  mdc_pkg::mdc_tmr_s st;
  mdc_pkg::mdc_tmr_s next_st;

  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.cnt = count_i;
    end else if (st.cnt != 6'h00) begin
      next_st.cnt = st.cnt - 6'h01;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= mdc_pkg::TMR_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = (st.cnt != 6'h00);
  assign last_o = (st.cnt == 6'h01);

endmodule

// ### core/mdc_unit.sv
`timescale 1ns/10ps
module mdc_unit (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Instruction request
  input wire logic start_i,
  input wire mdc_pkg::mdc_op_e op_i,
  input wire mdc_pkg::mdc_src_e src_i,
  input wire logic [31:0] acc_i,
  input wire logic [31:0] operand_i,
  input wire logic [3:0] addr_corr_i,
  // Progress
  output logic busy_o,
  output logic done_o,
  // Results
  output logic [31:0] acc_o,
  output logic acc_we_o,
  output logic [15:0] operand_o,
  output logic operand_we_o,
  output logic [3:0] flags_o,
  output logic [3:0] flag_we_o,
  // Memory operand traffic
  output logic mem_rd_o,
  output logic mem_wr_o
);

  mdc_pkg::mdc_state_s st;
  mdc_pkg::mdc_state_s next_st;

  logic taken;
  logic load;
  mdc_pkg::mdc_cyc_t cyc;
  mdc_pkg::mdc_cyc_t corr;
  logic tmr_busy;
  logic tmr_last;
  logic [1:0] row;
  logic acc_only;
  logic sgn;
  logic bw;
  logic is_div;
  logic [31:0] dd;
  logic [15:0] ds;
  logic dd_neg;
  logic ds_neg;
  logic [31:0] dd_mag;
  logic [15:0] ds_mag;
  logic [31:0] q_mag;
  logic [15:0] r_mag;
  logic [31:0] quo;
  logic [15:0] rem;
  logic [31:0] lim;
  logic div0;
  logic ovf;
  logic ovf_early;
  logic [31:0] ma;
  logic [31:0] mb;
  logic [31:0] prod;
  logic mzero;
  logic mneg;
  logic [31:0] ca;
  logic [31:0] cb;
  logic [1:0] cidx;

  function automatic logic [1:0] row_of(mdc_pkg::mdc_src_e s);
    if (s == mdc_pkg::src_acc) begin
      return mdc_pkg::ROW_ACC;
    end else if (s == mdc_pkg::src_mem) begin
      return mdc_pkg::ROW_MEM;
    end
    return mdc_pkg::ROW_REG;
  endfunction

  // Operands arrive left aligned so one subtractor serves all three widths
  function automatic logic [3:0] sub_flags(logic [31:0] a, logic [31:0] b);
    logic [32:0] d;
    logic [3:0] f;
    d = {1'b0, a} - {1'b0, b};
    f[mdc_pkg::FLAG_N] = d[31];
    f[mdc_pkg::FLAG_Z] = (d[31:0] == 32'h0000_0000);
    f[mdc_pkg::FLAG_V] = (a[31] ^ b[31]) & (a[31] ^ d[31]);
    f[mdc_pkg::FLAG_C] = d[32];
    return f;
  endfunction

  mdc_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .load_i(load),
    .count_i(cyc),
    .busy_o(tmr_busy),
    .last_o(tmr_last)
  );

  assign taken = start_i && !tmr_busy;

  always_comb begin
    next_st = st;
    next_st.mem_rd = 1'b0;
    load = 1'b0;
    cyc = 6'h01;
    row = row_of(src_i);
    acc_only = (src_i == mdc_pkg::src_acc);
    corr = (src_i == mdc_pkg::src_mem) ? {2'b00, addr_corr_i} : 6'h00;
    sgn = (op_i == mdc_pkg::op_signed_quotient_byte) || (op_i == mdc_pkg::op_signed_quotient_word) ||
          (op_i == mdc_pkg::op_signed_product_byte) || (op_i == mdc_pkg::op_signed_product_word);
    bw = (op_i == mdc_pkg::op_unsigned_quotient_byte) || (op_i == mdc_pkg::op_signed_quotient_byte) ||
         (op_i == mdc_pkg::op_unsigned_product_byte) || (op_i == mdc_pkg::op_signed_product_byte);
    is_div = (op_i == mdc_pkg::op_unsigned_quotient_byte) || (op_i == mdc_pkg::op_signed_quotient_byte) ||
             (op_i == mdc_pkg::op_unsigned_quotient_word) || (op_i == mdc_pkg::op_signed_quotient_word);
    // Divider: magnitudes through one unsigned 32/16 divide, signs fixed afterwards
    if (bw) begin
      dd = {16'h0000, acc_only ? acc_i[31:16] : acc_i[15:0]};
      ds = {8'h00, acc_only ? acc_i[7:0] : operand_i[7:0]};
      if (sgn) begin
        dd = {{16{dd[15]}}, dd[15:0]};
        ds = {{8{ds[7]}}, ds[7:0]};
      end
    end else begin
      dd = acc_i;
      ds = operand_i[15:0];
    end
    dd_neg = sgn && dd[31];
    ds_neg = sgn && ds[15];
    dd_mag = dd_neg ? 32'h0000_0000 - dd : dd;
    ds_mag = ds_neg ? 16'h0000 - ds : ds;
    div0 = (ds_mag == 16'h0000);
    q_mag = div0 ? 32'h0000_0000 : dd_mag / {16'h0000, ds_mag};
    r_mag = div0 ? 16'h0000 : 16'(dd_mag % {16'h0000, ds_mag});
    quo = (dd_neg ^ ds_neg) ? 32'h0000_0000 - q_mag : q_mag;
    rem = dd_neg ? 16'h0000 - r_mag : r_mag;
    if (bw) begin
      lim = !sgn ? mdc_pkg::QLIM_UB : ((dd_neg ^ ds_neg) ? mdc_pkg::QLIM_SB_NEG : mdc_pkg::QLIM_SB_POS);
    end else begin
      lim = !sgn ? mdc_pkg::QLIM_UW : ((dd_neg ^ ds_neg) ? mdc_pkg::QLIM_SW_NEG : mdc_pkg::QLIM_SW_POS);
    end
    ovf = !div0 && (q_mag > lim);
    // Upper half not below divisor shows overflow before any quotient step
    ovf_early = !div0 && (bw ? (dd_mag[15:8] >= ds_mag[7:0]) : (dd_mag[31:16] >= ds_mag));
    // Multiplier
    if (bw) begin
      ma = {24'h00_0000, acc_only ? acc_i[23:16] : acc_i[7:0]};
      mb = {24'h00_0000, acc_only ? acc_i[7:0] : operand_i[7:0]};
      if (sgn) begin
        ma = {{24{ma[7]}}, ma[7:0]};
        mb = {{24{mb[7]}}, mb[7:0]};
      end
    end else begin
      ma = {16'h0000, acc_only ? acc_i[31:16] : acc_i[15:0]};
      mb = {16'h0000, acc_only ? acc_i[15:0] : operand_i[15:0]};
      if (sgn) begin
        ma = {{16{ma[15]}}, ma[15:0]};
        mb = {{16{mb[15]}}, mb[15:0]};
      end
    end
    prod = ma * mb;
    mzero = acc_only ? (ma == 32'h0000_0000) : (mb == 32'h0000_0000);
    mneg = bw ? prod[15] : prod[31];
    // Compare operands
    case (op_i)
      mdc_pkg::op_compare_byte: begin
        cidx = 2'h0;
        ca = {acc_only ? acc_i[23:16] : acc_i[7:0], 24'h00_0000};
        cb = {acc_only ? acc_i[7:0] : operand_i[7:0], 24'h00_0000};
      end
      mdc_pkg::op_compare_word: begin
        cidx = 2'h1;
        ca = {acc_only ? acc_i[31:16] : acc_i[15:0], 16'h0000};
        cb = {acc_only ? acc_i[15:0] : operand_i[15:0], 16'h0000};
      end
      default: begin
        cidx = 2'h2;
        ca = acc_i;
        cb = acc_only ? {16'h0000, acc_i[15:0]} : operand_i;
      end
    endcase

    if (taken) begin
      load = 1'b1;
      next_st.op = op_i;
      next_st.src = src_i;
      next_st.acc_res = acc_i;
      next_st.opnd_res = operand_i[15:0];
      next_st.flags = mdc_pkg::FLAGS_NONE;
      next_st.flag_we = mdc_pkg::FLAGS_NONE;
      next_st.acc_we = 1'b0;
      next_st.opnd_we = 1'b0;
      next_st.mem_rd = (src_i == mdc_pkg::src_mem);
      next_st.mem_wr = 1'b0;
      next_st.abort = 1'b0;
      next_st.sovf = 1'b0;
      if (is_div) begin
        next_st.flags[mdc_pkg::FLAG_V] = div0 || ovf;
        next_st.flags[mdc_pkg::FLAG_C] = div0;
        next_st.flag_we = mdc_pkg::FLAGS_VC;
        next_st.abort = div0 || ovf;
        next_st.sovf = sgn && ovf;
        if (!(div0 || ovf)) begin
          next_st.acc_we = 1'b1;
          next_st.opnd_we = !acc_only;
          // remainder write-back only on normal end
          next_st.mem_wr = (src_i == mdc_pkg::src_mem);
          if (bw && acc_only) begin
            next_st.acc_res = {8'h00, rem[7:0], 8'h00, quo[7:0]};
          end else if (bw) begin
            next_st.acc_res = {acc_i[31:16], 8'h00, quo[7:0]};
            next_st.opnd_res = {8'h00, rem[7:0]};
          end else begin
            next_st.acc_res = {acc_i[31:16], quo[15:0]};
            next_st.opnd_res = rem;
          end
        end else if (sgn && ovf) begin
          // partial quotient lands in the low part
          next_st.acc_we = 1'b1;
          next_st.acc_res = {acc_i[31:16], quo[15:0]};
        end
      end
      case (op_i)
        mdc_pkg::op_compare_byte, mdc_pkg::op_compare_word, mdc_pkg::op_compare_long: begin
          next_st.flags = sub_flags(ca, cb);
          next_st.flag_we = mdc_pkg::FLAGS_ALL;
          cyc = mdc_pkg::CYC_CMP[cidx][src_i] + corr;
        end
        mdc_pkg::op_unsigned_quotient_byte: begin
          cyc = mdc_pkg::CYC_UQB[row][div0 ? 0 : (ovf ? 1 : 2)] + corr;
        end
        mdc_pkg::op_unsigned_quotient_word: begin
          cyc = mdc_pkg::CYC_UQW[row][div0 ? 0 : (ovf ? 1 : 2)] + corr;
        end
        mdc_pkg::op_signed_quotient_byte: begin
          cyc = mdc_pkg::CYC_SQB[row][div0 ? 0 : (ovf ? (ovf_early ? 1 : 2) : 3)] + corr;
        end
        mdc_pkg::op_signed_quotient_word: begin
          cyc = mdc_pkg::CYC_SQW[dd_neg][row][div0 ? 0 : (ovf ? (ovf_early ? 1 : 2) : 3)] + corr;
        end
        mdc_pkg::op_unsigned_product_byte, mdc_pkg::op_signed_product_byte: begin
          next_st.acc_we = 1'b1;
          next_st.acc_res = {acc_i[31:16], prod[15:0]};
          if (sgn) begin
            cyc = mdc_pkg::CYC_SPB[row][mzero ? 0 : (mneg ? 2 : 1)] + corr;
          end else begin
            cyc = mdc_pkg::CYC_UPB[row][mzero ? 0 : 1] + corr;
          end
        end
        mdc_pkg::op_unsigned_product_word, mdc_pkg::op_signed_product_word: begin
          next_st.acc_we = 1'b1;
          next_st.acc_res = prod;
          if (sgn) begin
            cyc = mdc_pkg::CYC_SPW[row][mzero ? 0 : (mneg ? 2 : 1)] + corr;
          end else begin
            cyc = mdc_pkg::CYC_UPW[row][mzero ? 0 : 1] + corr;
          end
        end
        default: begin
          cyc = 6'h01;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= mdc_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Results stay on the ports after done; only the strobes are single cycle
  assign busy_o = tmr_busy;
  assign done_o = tmr_last;
  assign acc_o = st.acc_res;
  assign acc_we_o = tmr_last && st.acc_we;
  assign operand_o = st.opnd_res;
  assign operand_we_o = tmr_last && st.opnd_we;
  assign flags_o = st.flags;
  assign flag_we_o = tmr_last ? st.flag_we : mdc_pkg::FLAGS_NONE;
  assign mem_rd_o = st.mem_rd;
  assign mem_wr_o = tmr_last && st.mem_wr;

  // Checking helpers: cycles since the request and the latched correction
  logic [5:0] elapsed;
  logic [5:0] held_corr;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      elapsed <= 6'h00;
      held_corr <= 6'h00;
    end else if (taken) begin
      elapsed <= 6'h01;
      held_corr <= corr;
    end else if (tmr_busy) begin
      elapsed <= elapsed + 6'h01;
    end
  end

  default clocking cb_sys @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  a_cmp_no_store: assert property (
    done_o && (st.op inside {mdc_pkg::op_compare_byte, mdc_pkg::op_compare_word, mdc_pkg::op_compare_long})
    |-> !acc_we_o && !operand_we_o && (flag_we_o == 4'hf))
    else $error("compare stored a result or missed flags");

  a_quot_flags: assert property (
    done_o && (st.op inside {mdc_pkg::op_unsigned_quotient_byte, mdc_pkg::op_unsigned_quotient_word,
                             mdc_pkg::op_signed_quotient_byte, mdc_pkg::op_signed_quotient_word})
    |-> (flag_we_o == 4'h3))
    else $error("division touched flags other than V and C");

  a_rem_writeback: assert property (
    done_o && !st.abort && (st.op == mdc_pkg::op_unsigned_quotient_byte) && (st.src == mdc_pkg::src_reg)
    |-> operand_we_o && acc_we_o && (operand_o[15:8] == 8'h00))
    else $error("byte remainder not written back");

  a_prod_flags: assert property (
    done_o && (st.op inside {mdc_pkg::op_unsigned_product_byte, mdc_pkg::op_signed_product_byte,
                             mdc_pkg::op_unsigned_product_word, mdc_pkg::op_signed_product_word})
    |-> acc_we_o && (flag_we_o == 4'h0) && !operand_we_o)
    else $error("product changed flags or missed write");

  a_uqb_div0_time: assert property (
    taken && (op_i == mdc_pkg::op_unsigned_quotient_byte) && (src_i == mdc_pkg::src_acc) && (acc_i[7:0] == 8'h00)
    |-> !done_o ##3 done_o)
    else $error("zero divisor byte quotient not done in 3 cycles");

  a_uqw_div0_time: assert property (
    taken && (op_i == mdc_pkg::op_unsigned_quotient_word) && (src_i == mdc_pkg::src_reg)
    && (operand_i[15:0] == 16'h0000) |-> ##4 done_o && flags_o[mdc_pkg::FLAG_V])
    else $error("zero divisor word quotient not done in 4 cycles");

  a_uqb_mem_time: assert property (
    done_o && (st.op == mdc_pkg::op_unsigned_quotient_byte) && (st.src == mdc_pkg::src_mem)
    |-> elapsed == (st.flags[mdc_pkg::FLAG_C] ? 6'h06 : (st.abort ? 6'h09 : 6'h13)) + held_corr)
    else $error("memory byte quotient took the wrong time");

  a_upb_time: assert property (
    done_o && (st.op == mdc_pkg::op_unsigned_product_byte) && (st.src == mdc_pkg::src_acc)
    |-> (elapsed == 6'h03) || (elapsed == 6'h07))
    else $error("byte product time not 3 or 7");

  a_upw_long: assert property (
    taken && (op_i == mdc_pkg::op_unsigned_product_word) && (src_i == mdc_pkg::src_acc)
    && (acc_i[31:16] != 16'h0000) |-> ##11 done_o)
    else $error("word product not done in 11 cycles");

  a_sqw_normal: assert property (
    taken && (op_i == mdc_pkg::op_signed_quotient_word) && (src_i == mdc_pkg::src_reg) && !acc_i[31]
    && !div0 && !ovf |-> ##31 done_o && !flags_o[mdc_pkg::FLAG_V])
    else $error("positive signed word quotient not done in 31 cycles");

  a_sqw_neg_normal: assert property (
    taken && (op_i == mdc_pkg::op_signed_quotient_word) && (src_i == mdc_pkg::src_reg) && acc_i[31]
    && !div0 && !ovf |-> ##32 done_o)
    else $error("negative signed word quotient not done in 32 cycles");

  a_spw_zero: assert property (
    taken && (op_i == mdc_pkg::op_signed_product_word) && (src_i == mdc_pkg::src_acc)
    && (acc_i[31:16] == 16'h0000) |-> ##3 done_o && (acc_o == 32'h0000_0000))
    else $error("zero signed word product not done in 3 cycles");

  a_mem_access: assert property (
    done_o && st.mem_rd == 1'b0 && (st.src == mdc_pkg::src_mem)
    && (st.op inside {mdc_pkg::op_unsigned_quotient_byte, mdc_pkg::op_signed_quotient_byte})
    |-> (mem_wr_o == !st.abort) && ($past(tmr_busy) || $past(mem_rd_o)))
    else $error("memory division access count wrong");

  a_abort_clean: assert property (
    done_o && st.abort |-> flags_o[mdc_pkg::FLAG_V] && !operand_we_o && !mem_wr_o && (acc_we_o == st.sovf))
    else $error("aborted division wrote a result");

  c_cmp_done: cover property (done_o && (st.op == mdc_pkg::op_compare_long));
  c_mem_div_normal: cover property (done_o && mem_wr_o);
  c_signed_ovf: cover property (done_o && st.sovf);
  c_neg_product: cover property (done_o && (st.op == mdc_pkg::op_signed_product_word) && acc_o[31]);

endmodule
